// ### cfg_loader_pkg.sv
// Shared constants for the serial configuration loader.
`default_nettype none
package cfg_loader_pkg;
	localparam int CFG_WIDTH = 160;
	localparam int NUM_OUTS = 9;
	localparam int SYS_CLK_HZ = 50_000_000;
	localparam int SETTLE_TIME_MS = 10;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_MS * (SYS_CLK_HZ / 1000));
	localparam int SETTLE_CNT_W = 20;
	localparam logic [CFG_WIDTH-1:0] CFG_RESET = '0;
	typedef enum logic [2:0] {
		ST_DEFAULT = 3'h1,
		ST_SETTLING = 3'h2,
		ST_RUNNING = 3'h4
	} cfg_state_e;
endpackage
`default_nettype wire

// ### bit_sync2.sv
// Two flip-flop level synchroniser into the system clock domain.
`default_nettype none
module bit_sync2 #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Level
	input wire logic i_async,
	output logic o_sync
);
	logic meta_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule // bit_sync2
`default_nettype wire

// ### serial_synth_config_loader.sv
// Three-wire serial configuration port with output clock selection and tri-state.
`default_nettype none
module serial_synth_config_loader #(
	parameter int SETTLE_COUNT = cfg_loader_pkg::SETTLE_CYCLES,
	parameter int CFG_W = cfg_loader_pkg::CFG_WIDTH,
	parameter int OUTS = cfg_loader_pkg::NUM_OUTS
) (
	// System clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Serial programming pins
	input wire logic I_SHIFT_CLK,
	input wire logic I_SERIAL_DATA,
	input wire logic I_LOAD_STROBE,
	input wire logic I_POWERDOWN_TRISTATE_N,
	// Reference and synthesised clocks
	input wire logic I_REF_INPUT,
	input wire logic [OUTS-1:0] I_SYNTH_CLK,
	// Configuration to the frequency synthesis logic
	output logic [CFG_W-1:0] O_CONFIG,
	output logic O_PROGRAMMED,
	output logic O_SETTLED,
	output logic O_POWERED_DOWN,
	// Output clock pins, bit 0 is synth_out_1 and bit 8 is synth_out_9
	output logic [OUTS-1:0] O_SYNTH_OUT,
	output logic [OUTS-1:0] O_SYNTH_OUT_OE_N
);
	import cfg_loader_pkg::*;

	// SETTLE_COUNT is the settle window in system clocks; a bench may shorten it.

	// Shift clock domain. This logic runs only on the host's shift clock, which
	// stands still between words, so nothing here may wait for a later edge.
	// The toggle flips once per shift edge and is the only single-bit signal
	// that the system clock side synchronises to learn about shift activity.
	logic [CFG_W-1:0] shift_reg;
	logic [CFG_W-1:0] shift_next;
	logic shift_tgl_reg;

	assign shift_next = {shift_reg[CFG_W-2:0], I_SERIAL_DATA};

	// Each bit enters at the low end so that the first bit ends at the top.
	// After more than a full word only the bits sent last are kept.
	always_ff @(posedge I_SHIFT_CLK or posedge I_RST) begin
		if (I_RST) begin
			shift_reg <= CFG_RESET[CFG_W-1:0];
			shift_tgl_reg <= 1'b0;
		end else begin
			shift_reg <= shift_next;
			shift_tgl_reg <= ~shift_tgl_reg;
		end
	end

	// System clock domain.
	// Both pins pass two flip-flops before any logic reads them.
	logic strobe_s;
	logic pd_n_s;
	logic tgl_s;
	logic tgl_seen_reg;

	bit_sync2 #(.RESET_VAL(1'b0)) u_sync_strobe (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_async(I_LOAD_STROBE),
		.o_sync(strobe_s)
	);

	// The pin has an internal pull-up, so it resets to the inactive level.
	bit_sync2 #(.RESET_VAL(1'b1)) u_sync_pd (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_async(I_POWERDOWN_TRISTATE_N),
		.o_sync(pd_n_s)
	);

	// The toggle changes on the shift clock, so it is synchronised like a pin.
	bit_sync2 #(.RESET_VAL(1'b0)) u_sync_tgl (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_async(shift_tgl_reg),
		.o_sync(tgl_s)
	);

	// The word is only copied once the shift edge toggle has been seen and held
	// still for a cycle, so the shift register was quiet for at least one
	// system clock. A shift clock burst faster than that while the strobe is
	// high is a partial word anyway and the host is told to avoid it.
	// The word itself crosses as a bus qualified by that toggle. The toggle lags
	// the shift edge by up to two system clocks, so a shift edge in that window
	// may be caught half way; the next quiet cycle reloads the settled word, so
	// only a transient value can reach the latch, and only when shifting with the
	// strobe high.
	logic word_quiet;
	logic strobe_rise;
	logic strobe_prev_reg;
	logic latch_open;
	logic [CFG_W-1:0] cfg_reg;
	logic [CFG_W-1:0] cfg_next;
	logic cfg_change;

	assign word_quiet = (tgl_s == tgl_seen_reg);
	assign strobe_rise = strobe_s & ~strobe_prev_reg;
	assign latch_open = strobe_s & word_quiet;
	assign cfg_next = latch_open ? shift_reg : cfg_reg;
	// A strobe rise counts as a load even when the word is unchanged.
	assign cfg_change = latch_open & ((shift_reg != cfg_reg) | strobe_rise);

	// The strobe edge is remembered only once the latch has opened, so a rise
	// during a shift burst still counts as a load when the burst ends.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tgl_seen_reg <= 1'b0;
			strobe_prev_reg <= 1'b0;
			cfg_reg <= CFG_RESET[CFG_W-1:0];
		end else begin
			tgl_seen_reg <= tgl_s;
			strobe_prev_reg <= strobe_prev_reg ? strobe_s : latch_open;
			cfg_reg <= cfg_next;
		end
	end

	// Settling sequence after every load. The counter restarts on each change,
	// so a host that reprograms faster than the settle window never sees the
	// settled flag until it stops.
	cfg_state_e state_reg;
	cfg_state_e state_next;
	logic [SETTLE_CNT_W-1:0] settle_reg;
	logic [SETTLE_CNT_W-1:0] settle_next;
	logic settle_done;

	// The counter starts at zero; the flag rises in the cycle after its last value.
	assign settle_done = (settle_reg == SETTLE_CNT_W'(SETTLE_COUNT - 1));

	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		case (state_reg)
			ST_DEFAULT: begin
				if (cfg_change) begin
					state_next = ST_SETTLING;
					settle_next = '0;
				end
			end
			ST_SETTLING: begin
				if (cfg_change) begin
					settle_next = '0;
				end else if (settle_done) begin
					state_next = ST_RUNNING;
				end else begin
					settle_next = settle_reg + SETTLE_CNT_W'(1);
				end
			end
			ST_RUNNING: begin
				if (cfg_change) begin
					state_next = ST_SETTLING;
					settle_next = '0;
				end
			end
			// An illegal state code falls back to the unprogrammed state.
			default: begin
				state_next = ST_DEFAULT;
				settle_next = '0;
			end
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_reg <= ST_DEFAULT;
			settle_reg <= '0;
		end else begin
			state_reg <= state_next;
			settle_reg <= settle_next;
		end
	end

	// Status and configuration outputs. Power-down only tri-states the pins; the
	// latched word and the programmed flag are kept, so the outputs come back
	// with the same clocks when the pin is released.
	logic programmed_reg;
	logic pd_reg;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			programmed_reg <= 1'b0;
			pd_reg <= 1'b0;
		end else begin
			programmed_reg <= programmed_reg | cfg_change;
			pd_reg <= ~pd_n_s;
		end
	end

	assign O_CONFIG = cfg_reg;
	assign O_PROGRAMMED = programmed_reg;
	// The states are one-hot, so this compare is a single state bit.
	assign O_SETTLED = (state_reg == ST_RUNNING);
	assign O_POWERED_DOWN = pd_reg;

	// The clock outputs are a pure mux of clocks; registering them would need a
	// clock faster than the fastest output.
	// A limitation: switching the source while both clocks run can clip one
	// output pulse at the moment of the first load.
	genvar g;
	generate
		for (g = 0; g < OUTS; g++) begin : g_out
			assign O_SYNTH_OUT[g] = programmed_reg ? I_SYNTH_CLK[g] : I_REF_INPUT;
			assign O_SYNTH_OUT_OE_N[g] = pd_reg;
		end
	endgenerate
endmodule // serial_synth_config_loader
`default_nettype wire

// ### serial_synth_config_loader_assertions.sv
// Port checker for the serial configuration loader.
`default_nettype none
module cfg_chk #(parameter int SETTLE_COUNT = 16, parameter int CFG_W = 160,
	parameter int OUTS = 9) (
	// Watched ports
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_LOAD_STROBE,
	input wire logic I_POWERDOWN_TRISTATE_N,
	input wire logic I_REF_INPUT,
	input wire logic [OUTS-1:0] I_SYNTH_CLK,
	input wire logic [CFG_W-1:0] O_CONFIG,
	input wire logic O_PROGRAMMED,
	input wire logic O_SETTLED,
	input wire logic O_POWERED_DOWN,
	input wire logic [OUTS-1:0] O_SYNTH_OUT,
	input wire logic [OUTS-1:0] O_SYNTH_OUT_OE_N
);
	localparam int SMAX = SETTLE_COUNT + 40;
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	property p_off; $fell(I_POWERDOWN_TRISTATE_N) |-> ##[2:4] &O_SYNTH_OUT_OE_N; endproperty
	a_off: assert property (p_off) else $error("no tristate");
	property p_on; $rose(I_POWERDOWN_TRISTATE_N) |-> ##[2:4] O_SYNTH_OUT_OE_N == '0; endproperty
	a_on: assert property (p_on) else $error("no drive");
	property p_pdf; !$past(I_RST, 1) && !$past(I_RST, 2) && !$past(I_RST, 3) |->
		O_POWERED_DOWN != $past(I_POWERDOWN_TRISTATE_N, 3); endproperty
	a_pdf: assert property (p_pdf) else $error("flag");
	property p_ref; !O_PROGRAMMED |-> O_SYNTH_OUT == {OUTS{I_REF_INPUT}}; endproperty
	a_ref: assert property (p_ref) else $error("ref");
	property p_syn; O_PROGRAMMED |-> O_SYNTH_OUT == I_SYNTH_CLK; endproperty
	a_syn: assert property (p_syn) else $error("synth");
	property p_hold; !I_LOAD_STROBE [*4] |-> $stable(O_CONFIG); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_load; $rose(I_LOAD_STROBE) |-> ##[3:8] O_PROGRAMMED && !O_SETTLED; endproperty
	a_load: assert property (p_load) else $error("load");
	property p_stl; $fell(O_SETTLED) |-> ##[1:SMAX] O_SETTLED; endproperty
	a_stl: assert property (p_stl) else $error("settle");
	property p_stk; O_PROGRAMMED |=> O_PROGRAMMED; endproperty
	a_stk: assert property (p_stk) else $error("sticky");
endmodule // cfg_chk
bind serial_synth_config_loader cfg_chk #(.SETTLE_COUNT(SETTLE_COUNT), .CFG_W(CFG_W),
	.OUTS(OUTS)) cfg_chk_inst (.*);
`default_nettype wire

// ### cfg_host.sv
// Host model that shifts words in over the three-wire port.
`default_nettype none
module cfg_host (
	// Serial pins
	output logic o_sclk,
	output logic o_data,
	output logic o_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_sclk = 1'b0;
		o_data = 1'b0;
		o_strobe = 1'b0;
	end
	// The 3 ns offset keeps link edges off the system clock edges.
	task automatic send(input logic [159:0] w, input int n, input bit hi);
		#3 o_strobe = hi;
		for (int i = n - 1; i >= 0; i--) begin
			o_data = w[i];
			#15 o_sclk = 1'b1;
			#15 o_sclk = 1'b0;
		end
		// The idle data line shows the inverse of the last bit sent.
		o_data = ~w[0];
		#200 o_strobe = 1'b1;
		#100 o_strobe = 1'b0;
	endtask
endmodule // cfg_host
`default_nettype wire

// ### serial_synth_config_loader_tb_top.sv
// Testbench for the serial configuration loader.
`default_nettype none
module serial_synth_config_loader_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cfg_loader_pkg::*;
	logic I_CLK = 1'b0;
	logic I_RST = 1'b1;
	logic I_REF_INPUT = 1'b0;
	logic I_POWERDOWN_TRISTATE_N = 1'b0;
	logic [NUM_OUTS-1:0] I_SYNTH_CLK = '0;
	logic I_SHIFT_CLK, I_SERIAL_DATA, I_LOAD_STROBE;
	logic [CFG_WIDTH-1:0] O_CONFIG, shadow = '0, w;
	logic [NUM_OUTS-1:0] O_SYNTH_OUT, O_SYNTH_OUT_OE_N;
	logic O_PROGRAMMED, O_SETTLED, O_POWERED_DOWN;
	logic [CFG_WIDTH-1:0] notes[$];
	int seed = 94108, err_total = 0, comparisons = 0;
	always #10 I_CLK = ~I_CLK;
	always @(posedge I_CLK) begin
		I_REF_INPUT <= ~I_REF_INPUT;
		I_SYNTH_CLK <= NUM_OUTS'($random(seed));
	end
	cfg_host cfg_host_inst (.o_sclk(I_SHIFT_CLK), .o_data(I_SERIAL_DATA), .o_strobe(I_LOAD_STROBE));
	serial_synth_config_loader #(.SETTLE_COUNT(16)) serial_synth_config_loader_inst (.*);
	task automatic chk(input bit ok);
		comparisons++;
		if (!ok) begin
			err_total++;
			$display("CHECK FAILED at %0t: mismatch", $time);
		end
	endtask
	task automatic load(input bit hi, input int n);
		w = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
		for (int i = n - 1; i >= 0; i--) shadow = {shadow[CFG_WIDTH-2:0], w[i]};
		notes.push_back(shadow);
		cfg_host_inst.send(w, n, hi);
		repeat (30) @(posedge I_CLK);
	endtask
	always @(negedge I_LOAD_STROBE) begin
		if (!I_RST) begin
			repeat (2) @(posedge I_CLK);
			#1 chk(notes.size() > 0 && O_CONFIG === notes.pop_front());
		end
	end
	task automatic wrap_up;
		$display("Comparisons %0d, errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#60us;
		err_total++;
		wrap_up;
	end
	initial begin
		repeat (12) @(posedge I_CLK);
		I_RST <= 1'b0;
		repeat (4) @(posedge I_CLK);
		#1 chk(O_PROGRAMMED === 1'b0 && O_SYNTH_OUT_OE_N === '1);
		chk(O_SETTLED === 1'b0 && O_SYNTH_OUT === {NUM_OUTS{I_REF_INPUT}});
		load(1'b0, CFG_WIDTH);
		@(posedge I_CLK) I_POWERDOWN_TRISTATE_N <= 1'b1;
		repeat (5) @(posedge I_CLK);
		#1 chk(O_SYNTH_OUT_OE_N === '0 && O_PROGRAMMED === 1'b1);
		chk(O_SETTLED === 1'b1 && O_SYNTH_OUT === I_SYNTH_CLK);
		load(1'b0, CFG_WIDTH);
		load(1'b1, 4);
		@(posedge I_CLK) I_POWERDOWN_TRISTATE_N <= 1'b0;
		repeat (5) @(posedge I_CLK);
		#1 chk(O_POWERED_DOWN === 1'b1 && O_CONFIG === shadow);
		@(posedge I_CLK) I_RST <= 1'b1;
		I_POWERDOWN_TRISTATE_N <= 1'b1;
		repeat (2) @(posedge I_CLK);
		#1 chk(O_CONFIG === '0 && O_PROGRAMMED === 1'b0);
		chk(O_SETTLED === 1'b0 && O_SYNTH_OUT === {NUM_OUTS{I_REF_INPUT}});
		@(posedge I_CLK) I_RST <= 1'b0;
		shadow = '0;
		load(1'b0, CFG_WIDTH);
		wrap_up;
	end
endmodule // serial_synth_config_loader_tb_top
`default_nettype wire
